// ---- valley_mode_pwm_control.sv ----
// Half-bridge PWM mode control with valley switching, gap mode and overcurrent protection.
`timescale 1ns/100ps
`include "valley_pwm_params.svh"

// Behaviour
// - Valley mode inserts a controlled idle gap after each high plus low side cycle.
// - Low side pulse starts at the first rising crossing after target valleys plus a configurable delay.
// - After the pulse, a configurable dead time precedes high side turn-on.
// - Dead time before low side turn-on is shared by valley and continuous modes.
// - Pulse length is negative target times inductance over ratio times output, clamped.
// - One valley counts per filtered falling edge of the zero-cross signal.
// - Each cycle target valleys rise below upper threshold, fall above lower threshold.
// - Threshold hysteresis equals one third of the nominal peak setting.
// - Thresholds rise with output voltage, interpolated toward a ratio at zero output.
// - Target valleys clamp at the maximum; a request beyond enters gap mode.
// - Gap mode lengthens the gap and starts the pulse without crossing detection.
// - Gap lengthening stops once the bridge period reaches the minimum frequency.
// - A configuration bit disables gap mode entirely.
// - Set-point follows feedback; separate threshold pairs govern leaving and returning continuous.
// - Entering gap mode adds a quarter of the upper threshold to the peak.
// - Gap mode counts valleys; fewer than maximum at pulse start returns to valley mode.
// - Above nominal set-point, every mode extends transfer time; peak is set-point less the negative target.
// - Overcurrent above set-point for the set duration halts switching and flags a fault.
module valley_mode_pwm_control
   import valley_pwm_pkg::*;
(
   input  wire logic        aclk,                 // System clock, 100 MHz.
   input  wire logic        aresetn,              // Synchronous reset, active low.
   input  wire logic [5:0]  awaddr,               // Write address.
   input  wire logic        awvalid,              // Write address valid.
   output logic             awready,              // Write address ready.
   input  wire logic [31:0] wdata,                // Write data.
   input  wire logic [3:0]  wstrb,                // Write byte strobes.
   input  wire logic        wvalid,               // Write data valid.
   output logic             wready,               // Write data ready.
   output logic [1:0]       bresp,                // Write response.
   output logic             bvalid,               // Write response valid.
   input  wire logic        bready,               // Write response ready.
   input  wire logic [5:0]  araddr,               // Read address.
   input  wire logic        arvalid,              // Read address valid.
   output logic             arready,              // Read address ready.
   output logic [31:0]      rdata,                // Read data.
   output logic [1:0]       rresp,                // Read response.
   output logic             rvalid,               // Read data valid.
   input  wire logic        rready,               // Read data ready.
   input  wire logic        zero_cross_input,     // Zero-cross comparator pin.
   input  wire logic        peak_trip,            // Peak current comparator pin.
   input  wire logic [15:0] setpoint_level,       // Current set-point derived from feedback.
   input  wire logic [15:0] output_level,         // Output voltage sensed on the zero-cross input.
   input  wire logic [15:0] current_estimate,     // Estimated output current.
   output logic             high_side_gate,       // High side switch drive.
   output logic             low_side_gate,        // Low side switch drive.
   output logic [2:0]       active_mode,          // Encoded operating mode.
   output logic [15:0]      peak_current_setting, // Peak current for the current comparator.
   output logic             protect_fault         // Overcurrent protection fault.
);

   // ---------------------------------------------------------------
   // Arithmetic helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            r[i*8 +: 8] = new_v[i*8 +: 8];
      return r;
   endfunction

   function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
      return (a > b) ? a - b : 16'h0000;
   endfunction

   function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[16] ? `CNT_MAX : s[15:0];
   endfunction

   // Division by a variable is costly but runs only on slow-moving operands.
   function automatic logic [15:0] zvs_len(input logic [15:0] neg, input logic [15:0] lm,
                                           input logic [7:0] n, input logic [15:0] v,
                                           input logic [15:0] lmin);
      logic [31:0] num;
      logic [23:0] den;
      logic [31:0] t;
      logic [15:0] r;
      num = neg * lm;
      den = n * v;
      t   = (den == 24'h00_0000) ? 32'hFFFF_FFFF : num / {8'h00, den};
      r   = (t[31:16] != 16'h0000) ? `CNT_MAX : t[15:0];
      return (r < lmin) ? lmin : r;
   endfunction

   function automatic logic [15:0] upper_thr(input logic [15:0] nom, input logic [7:0] ratio,
                                             input logic [7:0] out8);
      logic [23:0] p;
      logic [15:0] z;
      logic [23:0] d;
      p = nom * ratio;
      z = p[23:`SHIFT_FRAC];
      d = (nom - z) * out8;
      return z + d[23:`SHIFT_FRAC];
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   st_t         q;
   st_t         n;
   logic [3:0]  ar_idx;
   logic [31:0] ctrl_w;
   logic        run;
   logic        gap_en;
   logic        flt_clr;
   logic        flt_set;
   logic        zc_rise;
   logic        valley_pulse;
   logic        cycle_end;
   logic [15:0] up_thr;
   logic [15:0] lo_thr;
   logic [15:0] base_peak;
   logic [15:0] peak_d;
   logic [15:0] trans_time;
   logic [15:0] pulse_len;
   logic [3:0]  max_val;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb
   begin
      n            = q;
      ar_idx       = araddr[`IDX_RANGE];
      ctrl_w       = q.cfg[`REG_CTRL];
      run          = ctrl_w[`CTRL_RUN];
      gap_en       = ctrl_w[`CTRL_GAP_EN];
      flt_clr      = 1'b0;
      flt_set      = 1'b0;
      cycle_end    = 1'b0;
      max_val      = q.cfg[`REG_RATIO][`F_VALMAX];

      // Zero-cross pin passes three flops and trip pin two; logic reads the second, and the third for zero-cross edges.
      n.zc1        = zero_cross_input;
      n.zc2        = q.zc1;
      n.zc3        = q.zc2;
      n.tr1        = peak_trip;
      n.tr2        = q.tr1;
      zc_rise      = q.zc2 & ~q.zc3;
      n.filt       = q.zc2 ? 16'h0000 : ((q.filt == `CNT_MAX) ? q.filt : q.filt + 16'h0001);
      valley_pulse = ~q.zc2 & (q.filt == q.cfg[`REG_TIMING0][`F_HI16]);

      up_thr    = upper_thr(q.cfg[`REG_PEAK][`F_LO16], q.cfg[`REG_RATIO][`F_B1],
                            output_level[`F_SIG8]);
      lo_thr    = sat_add(up_thr, q.cfg[`REG_PEAK][`F_LO16] / `HYS_DIV);
      base_peak = sat_sub(setpoint_level, q.cfg[`REG_ZVS][`F_LO16]);
      peak_d    = (q.mode == MODE_GAP) ? sat_add(base_peak, {2'h0, up_thr[15:2]}) : base_peak;
      trans_time = sat_add(q.cfg[`REG_TRANS][`F_LO16],
                           sat_sub(setpoint_level, q.cfg[`REG_TRANS][`F_HI16]));
      pulse_len = zvs_len(q.cfg[`REG_ZVS][`F_LO16], q.cfg[`REG_ZVS][`F_HI16],
                          q.cfg[`REG_RATIO][`F_B0], output_level,
                          q.cfg[`REG_TIMING2][`F_LO16]);
      n.peak    = peak_d;

      // -------- Register bus: write side --------
      if (awvalid && q.axi.awready)
      begin
         n.axi.aw_have = 1'b1;
         n.axi.aw_idx  = awaddr[`IDX_RANGE];
         n.axi.awready = 1'b0;
      end
      if (wvalid && q.axi.wready)
      begin
         n.axi.w_have = 1'b1;
         n.axi.wdata  = wdata;
         n.axi.wstrb  = wstrb;
         n.axi.wready = 1'b0;
      end
      if (q.axi.aw_have && q.axi.w_have && !q.axi.bvalid)
      begin
         n.axi.aw_have = 1'b0;
         n.axi.w_have  = 1'b0;
         n.axi.bvalid  = 1'b1;
         n.axi.bresp   = (q.axi.aw_idx <= `REG_LAST_RW) ? `AXI_OKAY : `AXI_SLVERR;
         if (q.axi.aw_idx <= `REG_LAST_RW)
            n.cfg[q.axi.aw_idx] = merge_strb(q.cfg[q.axi.aw_idx], q.axi.wdata, q.axi.wstrb);
         if (q.axi.aw_idx == `REG_CTRL)
         begin
            // The clear bit is a command and is never stored.
            n.cfg[`REG_CTRL][`CTRL_FLT_CLR] = 1'b0;
            flt_clr = q.axi.wstrb[0] & q.axi.wdata[`CTRL_FLT_CLR];
         end
      end
      if (q.axi.bvalid && bready)
      begin
         n.axi.bvalid  = 1'b0;
         n.axi.awready = 1'b1;
         n.axi.wready  = 1'b1;
      end

      // -------- Register bus: read side --------
      if (arvalid && q.axi.arready)
      begin
         n.axi.arready = 1'b0;
         n.axi.rvalid  = 1'b1;
         n.axi.rresp   = `AXI_OKAY;
         n.axi.rdata   = 32'h0000_0000;
         if (ar_idx <= `REG_LAST_RW)
            n.axi.rdata = q.cfg[ar_idx];
         else if (ar_idx == `REG_STATUS)
         begin
            n.axi.rdata[`ST_MODE]   = q.mode;
            n.axi.rdata[`ST_FAULT]  = q.fault;
            n.axi.rdata[`ST_TARGET] = q.target;
            n.axi.rdata[`ST_PEAK]   = q.peak;
         end
         else
            n.axi.rresp = `AXI_SLVERR;
      end
      if (q.axi.rvalid && rready)
      begin
         n.axi.rvalid  = 1'b0;
         n.axi.arready = 1'b1;
      end

      // -------- Overcurrent supervision --------
      if (current_estimate > q.cfg[`REG_OCP][`F_LO16])
      begin
         n.oc_cnt = sat_add(q.oc_cnt, 16'h0001);
         flt_set  = (q.oc_cnt >= q.cfg[`REG_OCP][`F_HI16]);
      end
      else
         n.oc_cnt = 16'h0000;
      // A trip in the cycle of a clear keeps the fault.
      n.fault = (q.fault & ~flt_clr) | flt_set;

      // -------- Half-bridge sequencing --------
      n.cnt = sat_add(q.cnt, 16'h0001);
      n.per = sat_add(q.per, 16'h0001);
      if (!run || q.fault)
      begin
         n.phase  = q.fault ? PH_HALT : PH_IDLE;
         n.cnt    = 16'h0000;
         n.valley = 4'h0;
      end
      else
      begin
         unique case (q.phase)
            PH_IDLE, PH_HALT:
            begin
               n.phase = PH_ZVS;
               n.cnt   = 16'h0000;
            end
            PH_HS_ON:
               if (q.tr2)
               begin
                  n.phase   = PH_DEAD_L;
                  n.cnt     = 16'h0000;
                  cycle_end = 1'b1;
               end
            PH_DEAD_L:
               if (q.cnt >= q.cfg[`REG_TIMING1][`F_HI16])
               begin
                  n.phase = PH_LS_ON;
                  n.cnt   = 16'h0000;
               end
            PH_LS_ON:
               if (q.cnt >= trans_time)
               begin
                  n.phase  = (q.mode == MODE_CONT) ? PH_DEAD_H : PH_GAP;
                  n.cnt    = 16'h0000;
                  n.valley = 4'h0;
               end
            PH_GAP:
            begin
               if (valley_pulse && q.valley != `VALLEY_SAT)
                  n.valley = q.valley + 4'h1;
               if (q.mode == MODE_GAP)
               begin
                  if (q.cnt >= q.dcm_gap)
                  begin
                     n.phase = PH_ZVS;
                     n.cnt   = 16'h0000;
                     if (q.valley < max_val)
                     begin
                        n.mode   = MODE_VALLEY;
                        n.target = (max_val == 4'h0) ? `VALLEY_MIN : max_val;
                     end
                  end
               end
               else if (q.valley >= q.target && zc_rise)
               begin
                  n.phase = PH_DELAY;
                  n.cnt   = 16'h0000;
               end
            end
            PH_DELAY:
               if (q.cnt >= q.cfg[`REG_TIMING0][`F_LO16])
               begin
                  n.phase = PH_ZVS;
                  n.cnt   = 16'h0000;
               end
            PH_ZVS:
               if (q.cnt >= pulse_len)
               begin
                  n.phase = PH_DEAD_H;
                  n.cnt   = 16'h0000;
               end
            PH_DEAD_H:
               if (q.cnt >= q.cfg[`REG_TIMING1][`F_LO16])
               begin
                  n.phase    = PH_HS_ON;
                  n.cnt      = 16'h0000;
                  n.per      = 16'h0000;
                  n.last_per = q.per;
               end
            default:
            begin
               n.phase = PH_IDLE;
               n.cnt   = 16'h0000;
            end
         endcase
      end

      // -------- Once-per-cycle mode decisions --------
      if (cycle_end)
      begin
         unique case (q.mode)
            MODE_CONT:
               if (setpoint_level[`F_SIG8] < q.cfg[`REG_THR][`F_B0] ||
                   output_level[`F_SIG8] < q.cfg[`REG_THR][`F_B1])
               begin
                  n.mode   = MODE_VALLEY;
                  n.target = `VALLEY_MIN;
               end
            MODE_VALLEY:
               if (setpoint_level[`F_SIG8] > q.cfg[`REG_THR][`F_B2] &&
                   output_level[`F_SIG8] > q.cfg[`REG_THR][`F_B3])
                  n.mode = MODE_CONT;
               else if (q.peak < up_thr)
               begin
                  if (q.target < max_val)
                     n.target = q.target + 4'h1;
                  else if (gap_en)
                  begin
                     n.mode    = MODE_GAP;
                     n.dcm_gap = q.cnt;
                  end
               end
               else if (q.peak > lo_thr && q.target > `VALLEY_MIN)
                  n.target = q.target - 4'h1;
            MODE_GAP:
               if (!gap_en)
                  n.mode = MODE_VALLEY;
               else if (setpoint_level[`F_SIG8] > q.cfg[`REG_THR][`F_B2] &&
                        output_level[`F_SIG8] > q.cfg[`REG_THR][`F_B3])
                  n.mode = MODE_CONT;
               else if (q.peak < up_thr && q.last_per < q.cfg[`REG_PEAK][`F_HI16])
                  n.dcm_gap = sat_add(q.dcm_gap, `DCM_GAP_STEP);
               else if (q.peak > lo_thr)
                  n.dcm_gap = sat_sub(q.dcm_gap, `DCM_GAP_STEP);
            default:
               n.mode = MODE_CONT;
         endcase
      end

      n.hs = (n.phase == PH_HS_ON);
      n.ls = (n.phase == PH_LS_ON) || (n.phase == PH_ZVS);
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q             <= '0;
         q.axi.awready <= 1'b1;
         q.axi.wready  <= 1'b1;
         q.axi.arready <= 1'b1;
         q.cfg         <= {10{`CFG_RESET}};
         q.phase       <= PH_IDLE;
         q.mode        <= MODE_CONT;
         q.target      <= `VALLEY_MIN;
      end
      else
         q <= n;
   end

   assign awready              = q.axi.awready;
   assign wready               = q.axi.wready;
   assign bvalid               = q.axi.bvalid;
   assign bresp                = q.axi.bresp;
   assign arready              = q.axi.arready;
   assign rvalid               = q.axi.rvalid;
   assign rdata                = q.axi.rdata;
   assign rresp                = q.axi.rresp;
   assign high_side_gate       = q.hs;
   assign low_side_gate        = q.ls;
   assign active_mode          = q.mode;
   assign peak_current_setting = q.peak;
   assign protect_fault        = q.fault;

endmodule

// ---- valley_pwm_params.svh ----
// Register indices, field positions, reset values and fixed steps of the valley-mode PWM control.
`ifndef VALLEY_PWM_PARAMS_SVH
`define VALLEY_PWM_PARAMS_SVH

// Register indices; the byte address is the index times four.
`define REG_CTRL      4'h0
`define REG_TIMING0   4'h1
`define REG_TIMING1   4'h2
`define REG_TIMING2   4'h3
`define REG_ZVS       4'h4
`define REG_RATIO     4'h5
`define REG_PEAK      4'h6
`define REG_THR       4'h7
`define REG_OCP       4'h8
`define REG_TRANS     4'h9
`define REG_STATUS    4'hA
`define REG_LAST_RW   4'h9
`define IDX_RANGE     5:2

`define CTRL_RUN      0
`define CTRL_GAP_EN   1
`define CTRL_FLT_CLR  2
`define F_LO16        15:0
`define F_HI16        31:16
`define F_B0          7:0
`define F_B1          15:8
`define F_B2          23:16
`define F_B3          31:24
`define F_VALMAX      19:16
`define F_SIG8        15:8

`define ST_MODE       2:0
`define ST_FAULT      3
`define ST_TARGET     7:4
`define ST_PEAK       31:16

`define CFG_RESET     32'h0000_0000
`define AXI_OKAY      2'h0
`define AXI_SLVERR    2'h2
`define CNT_MAX       16'hFFFF
`define VALLEY_MIN    4'h1
`define VALLEY_SAT    4'hF
`define DCM_GAP_STEP  16'h0010
`define HYS_DIV       16'h0003
`define SHIFT_FRAC    8

`endif

// ---- valley_pwm_pkg.sv ----
// Types shared by the valley-mode PWM control.
package valley_pwm_pkg;

   typedef enum logic [8:0] {
      PH_IDLE   = 9'h001,
      PH_HS_ON  = 9'h002,
      PH_DEAD_L = 9'h004,
      PH_LS_ON  = 9'h008,
      PH_GAP    = 9'h010,
      PH_DELAY  = 9'h020,
      PH_ZVS    = 9'h040,
      PH_DEAD_H = 9'h080,
      PH_HALT   = 9'h100
   } phase_t;

   typedef enum logic [2:0] {
      MODE_CONT   = 3'h1,
      MODE_VALLEY = 3'h2,
      MODE_GAP    = 3'h4
   } mode_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        aw_have;
      logic        w_have;
      logic        bvalid;
      logic [1:0]  bresp;
      logic [3:0]  aw_idx;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } axi_st_t;

   typedef struct packed {
      axi_st_t          axi;
      logic [9:0][31:0] cfg;
      logic             zc1;
      logic             zc2;
      logic             zc3;
      logic             tr1;
      logic             tr2;
      phase_t           phase;
      mode_t            mode;
      logic             hs;
      logic             ls;
      logic             fault;
      logic [15:0]      cnt;
      logic [15:0]      filt;
      logic [15:0]      per;
      logic [15:0]      last_per;
      logic [15:0]      dcm_gap;
      logic [15:0]      oc_cnt;
      logic [15:0]      peak;
      logic [3:0]       valley;
      logic [3:0]       target;
   } st_t;

endpackage

// ---- valley_pwm_props.sv ----
// Concurrent checks on the ports of the valley-mode PWM control.
`timescale 1ns/100ps
module valley_pwm_props (
   input wire logic        aclk,           // Clock.
   input wire logic        aresetn,        // Reset, active low.
   input wire logic        arvalid,        // Read address valid.
   input wire logic        arready,        // Read address ready.
   input wire logic        rvalid,         // Read data valid.
   input wire logic        rready,         // Read data ready.
   input wire logic [31:0] rdata,          // Read data.
   input wire logic        bvalid,         // Write response valid.
   input wire logic        bready,         // Write response ready.
   input wire logic [1:0]  bresp,          // Write response.
   input wire logic        high_side_gate, // High side drive.
   input wire logic        low_side_gate,  // Low side drive.
   input wire logic [2:0]  active_mode,    // Operating mode.
   input wire logic        protect_fault   // Overcurrent fault.
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_no_overlap; !(high_side_gate && low_side_gate); endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("gates overlap");
   property p_mode_code; $onehot(active_mode); endproperty
   a_mode_code: assert property (p_mode_code) else $error("mode not one-hot");
   property p_hs_dead; $rose(high_side_gate) |-> !$past(low_side_gate); endproperty
   a_hs_dead: assert property (p_hs_dead) else $error("no dead time before high side");
   property p_ls_dead; $rose(low_side_gate) |-> !$past(high_side_gate); endproperty
   a_ls_dead: assert property (p_ls_dead) else $error("no dead time before low side");
   property p_fault_off; protect_fault |=> !high_side_gate && !low_side_gate; endproperty
   a_fault_off: assert property (p_fault_off) else $error("gates driven in fault");
   property p_mode_hs; !$stable(active_mode) |-> !high_side_gate; endproperty
   a_mode_hs: assert property (p_mode_hs) else $error("mode changed with high side on");
   property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_r_lat; arvalid && arready |=> rvalid; endproperty
   a_r_lat: assert property (p_r_lat) else $error("read answer late");
endmodule
bind valley_mode_pwm_control valley_pwm_props i_props (.*);

// ---- valley_pwm_partner.sv ----
// Behavioural half-bridge: current trip and decaying zero-cross ringing.
`timescale 1ns/100ps
module valley_pwm_partner (
   input  wire logic aclk, // Clock.
   input  wire logic hs,   // High side drive.
   input  wire logic ls,   // Low side drive.
   input  wire logic slow, // Short ringing, so the gap outlasts the valleys.
   output logic      trip, // Peak current comparator.
   output logic      zc    // Zero-cross comparator.
);
   logic [7:0] on_c = 8'h00;
   logic [7:0] ring_c = 8'h00;
   always @(posedge aclk)
   begin
      on_c <= hs ? on_c + 8'h01 : 8'h00;
      ring_c <= (hs || ls) ? 8'h00 : ring_c + {7'h00, ring_c != 8'hFF};
   end
   // The trip falls with the drive so a stale level never cuts the next pulse short.
   assign trip = on_c > 8'h05;
   assign zc = (ring_c < (slow ? 8'h10 : 8'hC0)) ? ring_c[2] : 1'b0;
endmodule

// ---- valley_mode_pwm_control_tb_top.sv ----
// Self-checking testbench of the valley-mode PWM control.
`timescale 1ns/100ps
`include "valley_pwm_params.svh"
module valley_mode_pwm_control_tb_top;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, slow = 0;
   logic [5:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, v, w;
   logic [3:0] wstrb = 4'hF;
   logic [15:0] setpoint_level = 0, output_level = 16'hFF00, current_estimate = 0;
   wire logic awready, wready, bvalid, arready, rvalid, zero_cross_input, peak_trip;
   wire logic high_side_gate, low_side_gate, protect_fault;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [2:0] active_mode;
   wire logic [15:0] peak_current_setting;
   int error_cnt = 0, n_compared = 0, cyc = 0, nhs = 0, g = 0, lg = 0, hg = 0, k;
   logic hsq = 0, lsq = 0, saw2 = 0, saw4 = 0;
   localparam logic [31:0] cfg_tab [9] = '{32'h0001_0002, 32'h0003_0002, 32'h4, 32'h0010_0010,
      32'h0002_8001, 32'h0400_0300, 32'h0, 32'h0004_FFFF, 32'hFFFF_0008};
   always #5 aclk = ~aclk;
   valley_mode_pwm_control i_dut (.*);
   valley_pwm_partner i_far (.aclk, .hs(high_side_gate), .ls(low_side_gate), .slow, .trip(peak_trip),
      .zc(zero_cross_input));
   // ----------------------------------------
   // Bus tasks and the gate monitor
   // ----------------------------------------
   task automatic end_sim;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic [31:0] exp_peak(input logic [15:0] sp, input logic [15:0] neg);
      return (sp > neg) ? {16'h0000, sp - neg} : 32'h0000_0000;
   endfunction
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] i, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= {i, 2'b00};
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end
      while (!bvalid);
      bready <= 0;
      cmp("bresp", er, bresp);
   endtask
   task automatic rd(input logic [3:0] i, input logic [1:0] er, output logic [31:0] q);
      @(posedge aclk);
      araddr <= {i, 2'b00};
      arvalid <= 1;
      rready <= 1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end
      while (!rvalid);
      q = rdata;
      rready <= 0;
      cmp("rresp", er, rresp);
   endtask
   always @(posedge aclk)
   begin
      cyc++;
      if (low_side_gate && !lsq) lg = g;
      if (high_side_gate && !hsq)
      begin
         nhs++;
         hg = g;
      end
      g = (high_side_gate || low_side_gate) ? 0 : g + 1;
      if (active_mode === 3'h2) saw2 = 1;
      if (active_mode === 3'h4) saw4 = 1;
      hsq = high_side_gate;
      lsq = low_side_gate;
      if (cyc == 30000)
      begin
         error_cnt++;
         end_sim;
      end
   end
   initial
   begin
      void'($urandom(37856));
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      rd(`REG_STATUS, `AXI_OKAY, v);
      cmp("status", 32'h1, v & 32'hFFFF_000F);
      for (k = 1; k < 10; k++)
      begin
         v = $urandom;
         wr(k[3:0], v, `AXI_OKAY);
         rd(k[3:0], `AXI_OKAY, w);
         cmp("reg", v, w);
      end
      wr(`REG_STATUS, 32'hFFFF_FFFF, `AXI_SLVERR);
      rd(4'hB, `AXI_SLVERR, w);
      cmp("unmapped", 32'h0, w);
      for (k = 1; k < 10; k++) wr(k[3:0], cfg_tab[k-1], `AXI_OKAY);
      setpoint_level <= 16'h0100 + 16'($urandom & 32'hFF);
      current_estimate <= 16'($urandom & 32'hFF);
      wr(`REG_CTRL, 32'h1, `AXI_OKAY);
      repeat (400) @(posedge aclk);
      cmp("hs pulses", 1, nhs > 2);
      cmp("ls dead", 4, lg);
      cmp("hs dead", 3, hg);
      cmp("mode", 1, active_mode);
      cmp("peak", exp_peak(setpoint_level, cfg_tab[3][15:0]), {16'h0000, peak_current_setting});
      wr(`REG_THR, 32'hFFFF_FFFF, `AXI_OKAY);
      repeat (800) @(posedge aclk);
      cmp("valley", 1, saw2);
      cmp("no gap", 0, saw4);
      cmp("hs dead rvs", 3, hg);
      rd(`REG_STATUS, `AXI_OKAY, w);
      cmp("target", cfg_tab[4][19:16], w[7:4]);
      cmp("stat mode", 2, w[2:0]);
      wr(`REG_CTRL, 32'h3, `AXI_OKAY);
      k = nhs;
      // Short ringing only once gap mode runs, so no valley-mode gap waits for a crossing that never comes.
      repeat (200) @(posedge aclk);
      slow <= 1;
      repeat (2800) @(posedge aclk);
      cmp("gap", 1, saw4);
      cmp("gap pulses", 1, nhs > k + 2);
      wr(`REG_OCP, 32'h0004_0100, `AXI_OKAY);
      current_estimate <= 16'h0200;
      repeat (12) @(posedge aclk);
      cmp("fault", 1, protect_fault);
      cmp("gates", 0, {high_side_gate, low_side_gate});
      rd(`REG_STATUS, `AXI_OKAY, w);
      cmp("stat fault", 1, w[3]);
      current_estimate <= 0;
      wr(`REG_CTRL, 32'h4, `AXI_OKAY);
      repeat (3) @(posedge aclk);
      cmp("clear", 0, protect_fault);
      end_sim;
   end
endmodule
